/* inc/sas_consts.svh */
// timing, width and layout constants for the conversion sequencer
// assumes a 250 MHz system clock; included by bare name
`ifndef SAS_CONSTS_SVH
`define SAS_CONSTS_SVH

// ----------------------------------------------------------------
// clock and documented times
// ----------------------------------------------------------------
`define SAS_CLK_MHZ 250
`define SAS_CONV_TIME_NS 8000
`define SAS_WAKE_TIME_NS 6000

// ----------------------------------------------------------------
// derived cycle counts
// ----------------------------------------------------------------
// one approximation step; longest time, so rounded down
`define SAS_STEP_CYC ((`SAS_CONV_TIME_NS * `SAS_CLK_MHZ / 1000) / `SAS_RES_BITS)
`define SAS_WAKE_CYC (`SAS_WAKE_TIME_NS * `SAS_CLK_MHZ / 1000)

// ----------------------------------------------------------------
// result and readout layout
// ----------------------------------------------------------------
`define SAS_RES_BITS 12
`define SAS_WORD_BITS 16
`define SAS_LEAD_ZEROS 4
`define SAS_CODE_TRIAL 12'h800
`define SAS_FIFO_DEPTH 8

`endif

/* inc/sas_pkg.sv */
// types shared by the conversion sequencer files
// assumes nothing beyond a SystemVerilog compiler
package sas_pkg;

    // result code, straight binary, 4096 levels
    typedef logic [11:0] sas_code_t;

    // sequencer states
    typedef enum logic [1:0] {
        SAS_TRACK,
        SAS_CONVERT,
        SAS_SLEEP,
        SAS_WAKE
    } sas_state_t;

endpackage : sas_pkg

/* design/sas_sync.sv */
// three-flop input synchroniser with agreement filter and edge pulses
// assumes an asynchronous level input and one system clock
`timescale 1ns/10ps
module sas_sync #(
    // reset level of the chain; set to the pin's idle level
    parameter logic INIT = 1'b1
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // raw input
    input wire logic async_in,
    // filtered level and one-cycle edges
    output logic level,
    output logic rise,
    output logic fall
);

    logic s1_reg, s2_reg, s3_reg;
    logic lvl_reg, lvl_next;

    // ----------------------------------------------------------------
    // level accepted once second and third stage agree
    // ----------------------------------------------------------------
    always_comb begin
        lvl_next = lvl_reg;
        if (s2_reg == s3_reg) begin
            lvl_next = s3_reg;
        end
    end

    // synchroniser chain and filtered level
    always_ff @(posedge clock) begin
        if (srst) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            lvl_reg <= INIT;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    // edge pulses from the filtered level
    assign level = lvl_reg;
    assign rise = lvl_next & ~lvl_reg;
    assign fall = ~lvl_next & lvl_reg;

endmodule : sas_sync

/* design/sas_fifo.sv */
// result fifo with valid/ready on both sides
// assumes DEPTH is a power of two
`timescale 1ns/10ps
module sas_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic do_wr, do_rd;

    // ----------------------------------------------------------------
    // honest full and empty from pointers with a wrap bit
    // ----------------------------------------------------------------
    assign in_ready = (wr_reg ^ rd_reg) != {1'b1, {AW{1'b0}}};
    assign out_valid = wr_reg != rd_reg;
    assign out_data = mem[rd_reg[AW-1:0]];
    assign do_wr = in_valid & in_ready;
    assign do_rd = out_valid & out_ready;

    // pointer next values
    always_comb begin
        wr_next = wr_reg + (AW+1)'(do_wr);
        rd_next = rd_reg + (AW+1)'(do_rd);
    end

    // pointers
    always_ff @(posedge clock) begin
        if (srst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    // storage
    always_ff @(posedge clock) begin
        if (do_wr) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end

endmodule : sas_fifo

/* design/sas_sequencer.sv */
// successive-approximation conversion sequencer with serial readout
// assumes comparator and start pin are asynchronous to clock; serial
// clock is sampled, not used as a clock
`timescale 1ns/10ps
`include "sas_consts.svh"
module sas_sequencer (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // conversion control pins
    input wire logic conversion_start_n,
    output logic busy,
    output logic power_down,
    // track/hold and approximation loop
    output logic hold_en,
    output sas_pkg::sas_code_t dac_code,
    input wire logic analog_above_dac,
    // serial readout
    input wire logic serial_clock,
    output logic serial_result_out,
    output logic serial_result_oe_n
);
    import sas_pkg::*;

    localparam int STEP_CYC = `SAS_STEP_CYC;
    localparam int WAKE_CYC = `SAS_WAKE_CYC;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic start_lvl, start_rise, start_fall;
    logic cmp_lvl, sclk_fall;

    sas_sync u_start (
        .clock(clock),
        .srst(srst),
        .async_in(conversion_start_n),
        .level(start_lvl),
        .rise(start_rise),
        .fall(start_fall)
    );

    sas_sync u_cmp (
        .clock(clock),
        .srst(srst),
        .async_in(analog_above_dac),
        .level(cmp_lvl),
        .rise(),
        .fall()
    );

    sas_sync #(.INIT(1'b0)) u_sclk (
        .clock(clock),
        .srst(srst),
        .async_in(serial_clock),
        .level(),
        .rise(),
        .fall(sclk_fall)
    );

    // ----------------------------------------------------------------
    // result fifo
    // ----------------------------------------------------------------
    logic push, fifo_in_ready, fifo_out_valid, pop;
    sas_code_t fifo_out_data;
    sas_code_t code_reg, code_next;

    sas_fifo #(
        .WIDTH(`SAS_RES_BITS),
        .DEPTH(`SAS_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .srst(srst),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(code_next), // last bit is decided in the push cycle
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    // ----------------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------------
    sas_state_t st_reg, st_next;
    logic busy_reg, busy_next, hold_reg, hold_next, pd_reg, pd_next;
    logic fell_reg, fell_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] step_cnt_reg, step_cnt_next;
    logic [10:0] wake_cnt_reg, wake_cnt_next;
    logic step_en;

    // internal conversion clock: one pulse per approximation step
    assign step_en = (st_reg == SAS_CONVERT) && (step_cnt_reg == 8'(STEP_CYC - 1));

    // next state of the sequencer
    always_comb begin
        st_next = st_reg;
        busy_next = busy_reg;
        hold_next = hold_reg;
        pd_next = pd_reg;
        code_next = code_reg;
        bit_next = bit_reg;
        step_cnt_next = step_cnt_reg;
        wake_cnt_next = wake_cnt_reg;
        fell_next = fell_reg;
        push = 1'b0;
        case (st_reg)
            SAS_TRACK: begin
                // refused while the fifo has no room for the result
                if (start_fall && fifo_in_ready) begin
                    st_next = SAS_CONVERT;
                    hold_next = 1'b1;
                    busy_next = 1'b1;
                    code_next = `SAS_CODE_TRIAL;
                    bit_next = 4'(`SAS_RES_BITS - 1);
                    step_cnt_next = 8'h00;
                end
            end
            SAS_CONVERT: begin
                // start edges here are ignored
                step_cnt_next = step_en ? 8'h00 : step_cnt_reg + 8'h01;
                if (step_en) begin
                    if (!cmp_lvl) begin
                        code_next[bit_reg] = 1'b0;
                    end
                    if (bit_reg == 4'h0) begin
                        push = 1'b1;
                        busy_next = 1'b0;
                        hold_next = 1'b0;
                        if (!start_lvl) begin
                            st_next = SAS_SLEEP;
                            pd_next = 1'b1;
                        end else begin
                            st_next = SAS_TRACK;
                        end
                    end else begin
                        code_next[bit_reg - 4'h1] = 1'b1;
                        bit_next = bit_reg - 4'h1;
                    end
                end
            end
            SAS_SLEEP: begin
                if (start_rise) begin
                    st_next = SAS_WAKE;
                    pd_next = 1'b0;
                    wake_cnt_next = 11'h000;
                    fell_next = 1'b0;
                end
            end
            SAS_WAKE: begin
                wake_cnt_next = wake_cnt_reg + 11'h001;
                if (start_fall && fifo_in_ready) begin
                    busy_next = 1'b1;
                    fell_next = 1'b1;
                end
                if (wake_cnt_reg == 11'(WAKE_CYC - 1)) begin
                    if (fell_next) begin
                        // short start pulse: hold once wake-up is over
                        st_next = SAS_CONVERT;
                        hold_next = 1'b1;
                        code_next = `SAS_CODE_TRIAL;
                        bit_next = 4'(`SAS_RES_BITS - 1);
                        step_cnt_next = 8'h00;
                    end else begin
                        // long start pulse: the falling edge starts it
                        st_next = SAS_TRACK;
                    end
                end
            end
            default: begin
                st_next = SAS_TRACK;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clock) begin
        if (srst) begin
            st_reg <= SAS_TRACK;
            busy_reg <= 1'b0;
            hold_reg <= 1'b0;
            pd_reg <= 1'b0;
            fell_reg <= 1'b0;
            code_reg <= 12'h000;
            bit_reg <= 4'h0;
            step_cnt_reg <= 8'h00;
            wake_cnt_reg <= 11'h000;
        end else begin
            st_reg <= st_next;
            busy_reg <= busy_next;
            hold_reg <= hold_next;
            pd_reg <= pd_next;
            fell_reg <= fell_next;
            code_reg <= code_next;
            bit_reg <= bit_next;
            step_cnt_reg <= step_cnt_next;
            wake_cnt_reg <= wake_cnt_next;
        end
    end

    // ----------------------------------------------------------------
    // serial readout
    // ----------------------------------------------------------------
    logic [15:0] word_reg, word_next, sh_reg, sh_next;
    logic [3:0] cnt_reg, cnt_next;
    logic ld_reg, ld_next, sdo_reg, sdo_next, oe_n_reg, oe_n_next;

    // next state of the shift register
    always_comb begin
        word_next = word_reg;
        sh_next = sh_reg;
        cnt_next = cnt_reg;
        ld_next = ld_reg;
        sdo_next = sdo_reg;
        oe_n_next = oe_n_reg;
        pop = 1'b0;
        if (start_fall) begin
            // back to the first bit of the held word
            sh_next = word_reg;
            cnt_next = 4'h0;
            sdo_next = word_reg[15];
            oe_n_next = ~ld_reg;
        end else if (!ld_reg) begin
            if (fifo_out_valid) begin
                word_next = {4'h0, fifo_out_data};
                sh_next = {4'h0, fifo_out_data};
                pop = 1'b1;
                ld_next = 1'b1;
                cnt_next = 4'h0;
                sdo_next = 1'b0;
                oe_n_next = 1'b0;
            end
        end else if (sclk_fall) begin
            if (cnt_reg == 4'hf) begin
                ld_next = 1'b0;
                oe_n_next = 1'b1;
                sdo_next = 1'b0;
            end else begin
                sh_next = {sh_reg[14:0], 1'b0};
                sdo_next = sh_reg[14];
                cnt_next = cnt_reg + 4'h1;
            end
        end
    end

    // readout registers
    always_ff @(posedge clock) begin
        if (srst) begin
            word_reg <= 16'h0000;
            sh_reg <= 16'h0000;
            cnt_reg <= 4'h0;
            ld_reg <= 1'b0;
            sdo_reg <= 1'b0;
            oe_n_reg <= 1'b1;
        end else begin
            word_reg <= word_next;
            sh_reg <= sh_next;
            cnt_reg <= cnt_next;
            ld_reg <= ld_next;
            sdo_reg <= sdo_next;
            oe_n_reg <= oe_n_next;
        end
    end

    // outputs straight from flip-flops
    assign busy = busy_reg;
    assign power_down = pd_reg;
    assign hold_en = hold_reg;
    assign dac_code = code_reg;
    assign serial_result_out = sdo_reg;
    assign serial_result_oe_n = oe_n_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    sequence s_sleep_wake;
        (st_reg == SAS_SLEEP && start_rise) ##1 (st_reg == SAS_WAKE);
    endsequence
    sequence s_track_start;
        st_reg == SAS_TRACK && start_fall && fifo_in_ready;
    endsequence

    a_start_hold_busy: assert property (s_track_start |=> hold_reg && busy_reg)
        else $error("start edge did not raise hold and busy");
    // cycles spent in hold; a conversion must end within 8 us
    logic [11:0] hold_cyc_reg, hold_cyc_next;
    assign hold_cyc_next = hold_reg ? hold_cyc_reg + 12'h001 : 12'h000;
    always_ff @(posedge clock) begin
        hold_cyc_reg <= srst ? 12'h000 : hold_cyc_next;
    end
    a_conv_time: assert property (hold_cyc_reg <= 12'h7d0)
        else $error("conversion exceeded its time");
    a_step_only_conv: assert property (step_en |-> st_reg == SAS_CONVERT && hold_reg)
        else $error("step pulse outside a conversion");
    a_end_tracks: assert property ($fell(busy_reg) |-> !hold_reg && $past(hold_reg))
        else $error("track/hold not released at conversion end");
    a_sleep_entry: assert property (step_en && bit_reg == 4'h0 && !start_lvl
        |=> pd_reg && st_reg == SAS_SLEEP)
        else $error("no power-down with start low at end");
    a_wake_powers: assert property (s_sleep_wake |-> !pd_reg)
        else $error("wake did not leave power-down");
    a_wake_hold: assert property (st_reg == SAS_WAKE && fell_reg
        && wake_cnt_reg == 11'(WAKE_CYC - 1) |=> hold_reg)
        else $error("hold not taken after wake-up time");
    a_ignore_start: assert property (st_reg == SAS_CONVERT && start_fall && !step_en
        |=> busy_reg && $stable(bit_reg))
        else $error("start edge disturbed a conversion");
    a_lead_zeros: assert property (ld_reg && cnt_reg < 4'(`SAS_LEAD_ZEROS) && !oe_n_reg
        |-> !sdo_reg)
        else $error("leading bit not zero");
    a_float_after: assert property (ld_reg && sclk_fall && !start_fall && cnt_reg == 4'hf
        |=> oe_n_reg && !ld_reg)
        else $error("output not floated after sixteenth edge");
    a_shift_reset: assert property (start_fall |=> cnt_reg == 4'h0)
        else $error("shift register not reset by start edge");

endmodule : sas_sequencer

/* bench/sas_host_model.sv */
// host and analog front end model facing the conversion sequencer
// assumes the bench calls read_bits shortly after a clock edge
`timescale 1ns/10ps
module sas_host_model (
    // analog side
    input wire sas_pkg::sas_code_t analog_value,
    input wire sas_pkg::sas_code_t dac_code,
    output logic analog_above_dac,
    // serial readout side
    output logic serial_clock,
    input wire logic serial_result_out,
    input wire logic serial_result_oe_n
);
    import sas_pkg::*;

    // ------------------------------------------------------------
    // comparator: input at or above trial code
    // ------------------------------------------------------------
    always_comb begin
        analog_above_dac = (analog_value >= dac_code);
    end

    // serial clock stands low between frames
    initial serial_clock = 1'b0;

    // ------------------------------------------------------------
    // reads n bits, sampling on each falling edge, 64 ns period
    // ------------------------------------------------------------
    // fl: output seen released at some point after the last falling edge
    task automatic read_bits(input int n, output logic [15:0] word, output logic oe_hi,
                             output logic fl);
        word = 16'h0000;
        oe_hi = 1'b0;
        fl = 1'b0;
        repeat (n) begin
            serial_clock = 1'b1;
            #32;
            serial_clock = 1'b0;
            // bit is still the old one here; a released line reads inverted
            word = {word[14:0], serial_result_oe_n ^ serial_result_out};
            oe_hi = oe_hi | serial_result_oe_n;
            fl = 1'b0;
            repeat (8) begin
                #4;
                fl = fl | serial_result_oe_n;
            end
        end
    endtask : read_bits
endmodule : sas_host_model

/* bench/sas_sequencer_test.sv */
// self-checking bench for the conversion sequencer
// assumes the host model drives serial clock and comparator
`timescale 1ns/10ps
module sas_sequencer_test;
    import sas_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic conversion_start_n = 1'b1;
    logic busy, power_down, hold_en, analog_above_dac, serial_clock;
    logic serial_result_out, serial_result_oe_n;
    sas_code_t dac_code;
    sas_code_t analog_value = 12'h000;
    int fail_count = 0;
    int tests_run = 0;

    always #2 clock = ~clock;

    sas_sequencer uut (
        .clock(clock), .srst(srst), .conversion_start_n(conversion_start_n),
        .busy(busy), .power_down(power_down), .hold_en(hold_en), .dac_code(dac_code),
        .analog_above_dac(analog_above_dac), .serial_clock(serial_clock),
        .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n)
    );

    sas_host_model host (
        .analog_value(analog_value), .dac_code(dac_code),
        .analog_above_dac(analog_above_dac), .serial_clock(serial_clock),
        .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic final_report();
        $display("counts: %0d compared, %0d mismatched", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_ok(input string what, input bit ok);
        tests_run++;
        if (!ok) begin
            fail_count++;
            $display("mismatch %s expected in bound seen outside", what);
        end
    endtask : chk_ok

    // inputs change 1 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    function automatic logic pick(input int s);
        return (s == 0) ? busy : (s == 1) ? hold_en : power_down;
    endfunction : pick

    // bounded wait for busy (0), hold (1) or power down (2)
    task automatic wait_lvl(input int s, input logic lvl, input int lim, output int n);
        n = 0;
        while (pick(s) !== lvl) begin
            if (n >= lim) begin
                fail_count++;
                $display("mismatch wait %0d expected %b seen %b", s, lvl, pick(s));
                final_report();
            end
            cyc(1);
            n++;
        end
    endtask : wait_lvl

    // one conversion; mode 0 start released, 1 kept low, 2 stray fall
    task automatic convert(input sas_code_t v, input int mode);
        int n;
        int extra;
        analog_value = v;
        conversion_start_n = 1'b0;
        wait_lvl(0, 1'b1, 8, n);
        chk("hold on start", 16'h0001, {15'h0, hold_en});
        cyc(3);
        extra = 3;
        if (mode != 1) begin
            conversion_start_n = 1'b1;
        end
        if (mode == 2) begin
            cyc(500);
            conversion_start_n = 1'b0;
            cyc(20);
            conversion_start_n = 1'b1;
            extra = 523;
        end
        wait_lvl(0, 1'b0, 2100, n);
        chk("busy length", 16'd1992, 16'(n + extra));
        chk("hold at end", 16'h0000, {15'h0, hold_en});
        cyc(2);
        chk("power down", 16'(mode == 1), {15'h0, power_down});
    endtask : convert

    task automatic read(input sas_code_t v);
        logic [15:0] w;
        logic oe_hi;
        logic fl;
        host.read_bits(16, w, oe_hi, fl);
        chk("read word", {4'h0, v}, w);
        chk("driving", 16'h0000, {15'h0, oe_hi});
        cyc(8);
        chk("float after", 16'h0001, {15'h0, fl});
    endtask : read

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        cyc(5);
        srst = 1'b0;
        cyc(1);
        chk("reset outs", 16'h0001, {12'h0, busy, power_down, hold_en, serial_result_oe_n});
        chk("reset code", 16'h0000, {4'h0, dac_code});
        $display("test reset done");
    endtask : t_reset

    task automatic t_codes();
        sas_code_t tbl [6] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'h001, 12'ha5c};
        realtime t0;
        foreach (tbl[i]) begin
            t0 = $realtime;
            convert(tbl[i], 0);
            cyc(4);
            read(tbl[i]);
            cyc(120);
            chk_ok("cycle time", ($realtime - t0) <= 10000.0);
        end
        $display("test codes done");
    endtask : t_codes

    task automatic t_stray();
        convert(12'h5a3, 2);
        cyc(4);
        read(12'h5a3);
        cyc(380);
        $display("test stray start done");
    endtask : t_stray

    task automatic t_sleep();
        int n;
        int m;
        convert(12'h3c5, 1);
        cyc(4);
        read(12'h3c5);
        conversion_start_n = 1'b1;
        wait_lvl(2, 1'b0, 8, n);
        m = n + 190;
        cyc(190);
        conversion_start_n = 1'b0;
        wait_lvl(1, 1'b1, 1400, n);
        m = m + n;
        chk_ok("wake to hold", m >= 1500 && m <= 1510);
        wait_lvl(0, 1'b0, 2100, n);
        chk_ok("wake to result", m + n <= 3510);
        cyc(2);
        chk("sleep again", 16'h0001, {15'h0, power_down});
        conversion_start_n = 1'b1;
        wait_lvl(2, 1'b0, 8, n);
        cyc(1600);
        read(12'h3c5);
        $display("test sleep done");
    endtask : t_sleep

    task automatic t_rewind();
        logic [15:0] w;
        logic oe_hi;
        logic fl;
        convert(12'h9b7, 0);
        cyc(4);
        host.read_bits(5, w, oe_hi, fl);
        cyc(380);
        convert(12'h246, 0);
        cyc(4);
        read(12'h9b7);
        read(12'h246);
        cyc(380);
        $display("test rewind done");
    endtask : t_rewind

    task automatic t_fifo();
        logic [15:0] w;
        logic oe_hi;
        logic fl;
        for (int i = 0; i < 9; i++) begin
            convert(sas_code_t'(12'h111 * (i + 1)), 0);
            cyc(380);
        end
        conversion_start_n = 1'b0;
        cyc(30);
        chk("refused start", 16'h0000, {15'h0, busy});
        conversion_start_n = 1'b1;
        for (int i = 0; i < 9; i++) begin
            cyc(300);
            read(sas_code_t'(12'h111 * (i + 1)));
        end
        host.read_bits(16, w, oe_hi, fl);
        chk("empty float", 16'h0001, {15'h0, oe_hi});
        $display("test fifo done");
    endtask : t_fifo

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        t_reset();
        t_codes();
        t_stray();
        t_sleep();
        t_rewind();
        t_fifo();
        final_report();
    end
endmodule : sas_sequencer_test
